// ---- smtx_regs.vh ----
`ifndef SMTX_REGS_VH
`define SMTX_REGS_VH

// Register indices; byte address is four times the index
`define SMTX_IDX_RX_STAT_CTRL   6'h13
`define SMTX_IDX_RX_DATA_BUF    6'h14
`define SMTX_IDX_TX_STAT_CTRL   6'h15
`define SMTX_IDX_TX_BUFFER      6'h16
`define SMTX_IDX_IRQ_FLAGS      6'h16
`define SMTX_IDX_BAUD_DIVISOR   6'h17
`define SMTX_IDX_IRQ_ENABLES    6'h17
`define SMTX_IDX_BANK_SELECT    6'h18

// receive_status_control fields
`define SMTX_RX_SERIAL_PORT_EN  7
`define SMTX_RX_NINE_BIT        6
`define SMTX_RX_SINGLE_EN       5
`define SMTX_RX_CONT_EN         4
`define SMTX_RX_NINTH_BIT       0

// transmit_status_control fields
`define SMTX_TX_CLK_SRC_MASTER  7
`define SMTX_TX_NINE_BIT        6
`define SMTX_TX_ENABLE          5
`define SMTX_TX_CLOCKED_MODE    4
`define SMTX_TX_SHIFTER_EMPTY   1
`define SMTX_TX_NINTH_BIT       0

// peripheral_irq_flags and peripheral_irq_enables fields
`define SMTX_IRQ_TX_BIT         1
`define SMTX_IRQ_RX_BIT         0

// Reset values
`define SMTX_RST_RX_STAT_CTRL   8'h00
`define SMTX_RST_TX_STAT_CTRL   8'h02
`define SMTX_RST_IRQ_FLAGS      8'h02
`define SMTX_RST_IRQ_ENABLES    8'h00
`define SMTX_RST_BAUD_DIVISOR   8'h00

// Word lengths in bits
`define SMTX_BITS_8             4'h8
`define SMTX_BITS_9             4'h9

`endif

// ---- smtx_top.v ----
`timescale 1ns/10ps
`include "smtx_regs.vh"

// Overview of operation
// R1: Transmit and receive never run together
// R2: Clocked mode bit enables synchronous operation
// R3: Port enable hands pins to clock/data
// R4: Master clock bit drives shift clock out
// R5: Shifter reloads only after last bit
// R6: Buffer transfer empties buffer, sets flag
// R7: Empty flag ignores enable; write clears it
// R8: Shifter-empty bit read-only, no interrupt path
// R9: Transmit enable plus buffered data starts shifting
// R10: Bits change on rising, stable at falling
// R11: Baud generator held reset when all disabled
// R12: Write to empty shifter transfers at once
// R13: Transmit disable aborts, floats both pins
// R14: Receive enable aborts, floats data only; here the transmit shifter freezes and resumes
// R15: Single receive self-clears, transmit resumes
// R16: Ninth bit sampled at shifter load
// R17: Software writes ninth bit before data
// R18: Software configures, loads, then enables
// R19: Core-level interrupt gating done by software
// R20: Port or transmit disable resets transmitter
// R21: LSB first, no start/stop framing
module smtx_top (
   input  wire        I_REF_CLK,
   input  wire        I_RST_N,
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [7:0]  I_PADDR,
   input  wire [31:0] I_PWDATA,
   output reg         O_PREADY,
   output reg  [31:0] O_PRDATA,
   output reg         O_PSLVERR,
   input  wire        I_CLK_PIN_IN,
   output reg         O_CLK_PIN_OUT,
   output reg         O_CLK_PIN_OE_N,
   input  wire        I_DATA_PIN_IN,
   output reg         O_DATA_PIN_OUT,
   output reg         O_DATA_PIN_OE_N
);

   // Control and status storage
   reg  [7:0] rx_ctrl_q;
   reg  [7:0] tx_ctrl_q;
   reg  [7:0] baud_div_q;
   reg  [7:0] irq_en_q;
   reg        bank_q;
   reg  [7:0] tx_buf_q;
   reg        tx_buf_full_q;
   reg  [8:0] rx_data_q;
   reg        rx_flag_q;

   // Shifter and baud generator state
   reg  [8:0] tsr_q;
   reg        tsr_full_q;
   reg  [3:0] tx_cnt_q;
   reg  [8:0] rsr_q;
   reg  [3:0] rx_cnt_q;
   reg        rx_armed_q;
   reg  [7:0] brg_cnt_q;
   reg        sck_q;

   // Pin synchronisers
   reg  [1:0] dt_sync_q;
   reg  [1:0] ck_sync_q;

   // Bus decode
   wire [5:0] idx      = I_PADDR[7:2];
   wire       setup    = I_PSEL & ~I_PENABLE;
   wire       access   = I_PSEL & I_PENABLE & O_PREADY;
   wire       wr_acc   = access & I_PWRITE;
   wire       rd_acc   = access & ~I_PWRITE;
   wire       bad_addr = ~mapped(idx, bank_q) | (I_PADDR[1:0] != 2'h0);

   // Mode decode
   wire port_en   = rx_ctrl_q[`SMTX_RX_SERIAL_PORT_EN];                    // [R3]
   wire sync_mode = tx_ctrl_q[`SMTX_TX_CLOCKED_MODE];                      // [R2]
   wire master    = tx_ctrl_q[`SMTX_TX_CLK_SRC_MASTER];                    // [R4]
   wire tx_en     = tx_ctrl_q[`SMTX_TX_ENABLE];
   wire rx_single = rx_ctrl_q[`SMTX_RX_SINGLE_EN];
   wire rx_cont   = rx_ctrl_q[`SMTX_RX_CONT_EN];
   wire rx_any    = rx_single | rx_cont;
   wire port_ok   = port_en & sync_mode & master;
   // Receive overrides transmit; shifter is frozen, not cleared
   wire tx_run    = port_ok & tx_en & ~rx_any;                             // [R1] [R14]
   wire rx_run    = port_ok & rx_any;                                      // [R1]
   wire tx_reset  = ~port_en | ~tx_en;                                     // [R20] [R13]
   wire brg_hold  = ~port_en | ~(tx_en | rx_any);                          // [R11]
   wire brg_tick  = ~brg_hold & (brg_cnt_q == 8'h00);
   wire tx_bits9  = tx_ctrl_q[`SMTX_TX_NINE_BIT];
   wire rx_bits9  = rx_ctrl_q[`SMTX_RX_NINE_BIT];
   wire clk_act   = (tx_run & tsr_full_q) | rx_run;
   wire rise_tick = brg_tick & clk_act & ~sck_q;
   wire fall_tick = brg_tick & sck_q;
   wire tx_last   = (tx_cnt_q == word_len(tx_bits9));
   wire rx_last   = (rx_cnt_q == word_len(rx_bits9));
   wire tx_done   = fall_tick & tx_run & tsr_full_q & tx_last;
   // A fall counts for receive only after a rise that receive owned
   wire rx_sample = fall_tick & rx_run & rx_armed_q;
   wire rx_done   = rx_sample & ((rx_cnt_q + 4'h1) == word_len(rx_bits9));
   // Load when the shifter is empty and a word is waiting
   wire tsr_load  = ~tx_reset & ~tsr_full_q & tx_buf_full_q;               // [R5] [R12] [R9]

   // Word length for either direction
   function [3:0] word_len;
      input nine;
      begin
         word_len = nine ? `SMTX_BITS_9 : `SMTX_BITS_8;
      end
   endfunction

   // Register read mux, bank select picks between shared indices
   function [7:0] read_mux;
      input [5:0] a;
      input       b;
      begin
         read_mux = 8'h00;
         if (a == `SMTX_IDX_RX_STAT_CTRL) begin
            read_mux = {rx_ctrl_q[7:4], 3'h0, rx_data_q[8]};
         end else if (a == `SMTX_IDX_RX_DATA_BUF) begin
            read_mux = rx_data_q[7:0];
         end else if (a == `SMTX_IDX_TX_STAT_CTRL) begin
            read_mux = {tx_ctrl_q[7:4], 2'h0, ~tsr_full_q, tx_ctrl_q[0]};  // [R8]
         end else if (a == `SMTX_IDX_TX_BUFFER && !b) begin
            read_mux = tx_buf_q;
         end else if (a == `SMTX_IDX_IRQ_FLAGS && b) begin
            read_mux = {6'h00, ~tx_buf_full_q, rx_flag_q};                  // [R6] [R7]
         end else if (a == `SMTX_IDX_BAUD_DIVISOR && !b) begin
            read_mux = baud_div_q;
         end else if (a == `SMTX_IDX_IRQ_ENABLES && b) begin
            read_mux = irq_en_q;
         end else if (a == `SMTX_IDX_BANK_SELECT) begin
            read_mux = {7'h00, bank_q};
         end
      end
   endfunction

   // Valid address check for the error answer
   function mapped;
      input [5:0] a;
      input       b;
      begin
         mapped = (a == `SMTX_IDX_RX_STAT_CTRL) || (a == `SMTX_IDX_RX_DATA_BUF)
               || (a == `SMTX_IDX_TX_STAT_CTRL) || (a == `SMTX_IDX_TX_BUFFER)
               || (a == `SMTX_IDX_BAUD_DIVISOR) || (a == `SMTX_IDX_BANK_SELECT);
      end
   endfunction

   // Two-flop synchronisers for pin inputs
   // Clock readback is kept synchronised but unused while only master mode exists
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         dt_sync_q <= 2'h0;
         ck_sync_q <= 2'h0;
      end else begin
         dt_sync_q <= {dt_sync_q[0], I_DATA_PIN_IN};
         ck_sync_q <= {ck_sync_q[0], I_CLK_PIN_IN};
      end
   end

   // APB slave: no wait states, answer registered in setup
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= setup;
         if (setup) begin
            // Refused transfers read back zero, as do writes
            if (I_PWRITE || bad_addr) begin
               O_PRDATA <= 32'h0000_0000;
            end else begin
               O_PRDATA <= {24'h00_0000, read_mux(idx, bank_q)};
            end
            O_PSLVERR <= bad_addr;
         end else begin
            // Error stands only with ready, never past the access cycle
            O_PSLVERR <= 1'b0;
         end
      end
   end

   // Software register writes
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tx_ctrl_q  <= `SMTX_RST_TX_STAT_CTRL;
         baud_div_q <= `SMTX_RST_BAUD_DIVISOR;
         irq_en_q   <= `SMTX_RST_IRQ_ENABLES;
         bank_q     <= 1'b0;
      end else if (wr_acc && !O_PSLVERR) begin
         if (idx == `SMTX_IDX_TX_STAT_CTRL) begin
            // Shifter-empty bit is never stored from the bus
            tx_ctrl_q <= {I_PWDATA[7:4], 2'h0, 1'b0, I_PWDATA[0]};          // [R8]
         end
         if (idx == `SMTX_IDX_BAUD_DIVISOR && !bank_q) begin
            baud_div_q <= I_PWDATA[7:0];
         end
         if (idx == `SMTX_IDX_IRQ_ENABLES && bank_q) begin
            irq_en_q <= I_PWDATA[7:0];                                     // [R7]
         end
         if (idx == `SMTX_IDX_BANK_SELECT) begin
            bank_q <= I_PWDATA[0];
         end
      end
   end

   // Receive control; single-word enable clears itself after a word
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rx_ctrl_q <= `SMTX_RST_RX_STAT_CTRL;
      end else if (wr_acc && !O_PSLVERR && idx == `SMTX_IDX_RX_STAT_CTRL) begin
         rx_ctrl_q <= {I_PWDATA[7:4], 4'h0};
      end else if (rx_done && !rx_cont) begin
         rx_ctrl_q[`SMTX_RX_SINGLE_EN] <= 1'b0;                             // [R15]
      end
   end

   // Transmit buffer; a write wins over a same-cycle transfer
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tx_buf_q      <= 8'h00;
         tx_buf_full_q <= 1'b0;
      end else if (wr_acc && !O_PSLVERR && !bank_q && idx == `SMTX_IDX_TX_BUFFER) begin
         tx_buf_q      <= I_PWDATA[7:0];
         tx_buf_full_q <= 1'b1;                                            // [R7]
      end else if (tsr_load) begin
         tx_buf_full_q <= 1'b0;                                            // [R6]
      end
   end

   // Baud generator, reloads from the divisor, held at zero when idle
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         brg_cnt_q <= 8'h00;
      end else if (brg_hold) begin
         brg_cnt_q <= 8'h00;                                               // [R11]
      end else if (brg_cnt_q == 8'h00) begin
         brg_cnt_q <= baud_div_q;
      end else begin
         brg_cnt_q <= brg_cnt_q - 8'h01;
      end
   end

   // Shift clock; rests low so the first edge after enable is a rise
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sck_q <= 1'b0;
      end else if (brg_hold || !port_ok) begin
         sck_q <= 1'b0;
      end else if (rise_tick || fall_tick) begin
         sck_q <= ~sck_q;                                                  // [R4] [R11]
      end
   end

   // Transmit shifter; frozen while a receive borrows the port
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tsr_q      <= 9'h000;
         tsr_full_q <= 1'b0;
         tx_cnt_q   <= 4'h0;
      end else if (tx_reset) begin
         tsr_full_q <= 1'b0;                                               // [R13] [R20]
         tx_cnt_q   <= 4'h0;
      end else if (tsr_load) begin
         // Ninth bit taken as it stands at load time
         tsr_q      <= {tx_ctrl_q[`SMTX_TX_NINTH_BIT], tx_buf_q};           // [R16] [R6]
         tsr_full_q <= 1'b1;
         tx_cnt_q   <= 4'h0;
      end else if (tx_done) begin
         tsr_full_q <= 1'b0;                                               // [R5]
      end else if (rise_tick && tx_run && tsr_full_q) begin
         tsr_q    <= {1'b0, tsr_q[8:1]};                                   // [R21]
         tx_cnt_q <= tx_cnt_q + 4'h1;
      end
   end

   // Receive arms on its own first rise; a takeover while the clock is
   // high would otherwise sample the bit still owned by the transmitter
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rx_armed_q <= 1'b0;
      end else if (!rx_run) begin
         rx_armed_q <= 1'b0;
      end else if (rise_tick) begin
         rx_armed_q <= 1'b1;                                               // [R1]
      end
   end

   // Receive shifter samples the data pin on falling edges
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rsr_q     <= 9'h000;
         rx_cnt_q  <= 4'h0;
         rx_data_q <= 9'h000;
         rx_flag_q <= 1'b0;
      end else begin
         if (!rx_run) begin
            rx_cnt_q <= 4'h0;
         end else if (rx_done) begin
            rx_cnt_q  <= 4'h0;
            rx_data_q <= rx_bits9 ? {dt_sync_q[1], rsr_q[8:1]}
                                  : {1'b0, dt_sync_q[1], rsr_q[8:2]};
         end else if (rx_sample) begin
            rsr_q    <= {dt_sync_q[1], rsr_q[8:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
         end
         // Hardware set wins over the clear by a read
         if (rx_done) begin
            rx_flag_q <= 1'b1;
         end else if (rd_acc && !bank_q && idx == `SMTX_IDX_RX_DATA_BUF) begin
            rx_flag_q <= 1'b0;
         end
      end
   end

   // Pin drivers; enables are active low
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_CLK_PIN_OUT   <= 1'b0;
         O_CLK_PIN_OE_N  <= 1'b1;
         O_DATA_PIN_OUT  <= 1'b0;
         O_DATA_PIN_OE_N <= 1'b1;
      end else begin
         O_CLK_PIN_OUT   <= sck_q;
         // Clock stays driven through a receive in master mode
         O_CLK_PIN_OE_N  <= ~(port_ok & (tx_en | rx_any));                 // [R3] [R13] [R14]
         O_DATA_PIN_OE_N <= ~tx_run;                                       // [R13] [R14] [R15]
         // Bit changes only on a rise, so it is steady at the fall
         if (rise_tick && tx_run && tsr_full_q) begin
            O_DATA_PIN_OUT <= tsr_q[0];                                    // [R10] [R21]
         end
      end
   end

endmodule

// ---- smtx_chk_sva.sv ----
`timescale 1ns/10ps
`include "smtx_regs.vh"
module smtx_chk (
   input logic        I_REF_CLK,
   input logic        I_RST_N,
   input logic        I_PSEL,
   input logic        I_PENABLE,
   input logic        I_PWRITE,
   input logic [7:0]  I_PADDR,
   input logic [31:0] I_PWDATA,
   input logic        O_PREADY,
   input logic [31:0] O_PRDATA,
   input logic        O_PSLVERR,
   input logic        O_CLK_PIN_OUT,
   input logic        O_CLK_PIN_OE_N,
   input logic        O_DATA_PIN_OUT,
   input logic        O_DATA_PIN_OE_N
);
   logic [7:0] rxc_q;
   logic [7:0] txc_q;
   wire        wr_ok = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY & !O_PSLVERR;
   wire        cfg_ok = rxc_q[7] & txc_q[7] & txc_q[4];
   wire        idle = !txc_q[5] & !rxc_q[5] & !rxc_q[4];
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   // Shadow of written controls; single-receive self-clear unseen, so checks only weaken
   always @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rxc_q <= 8'h00;
         txc_q <= 8'h00;
      end else if (wr_ok && I_PADDR == {`SMTX_IDX_RX_STAT_CTRL, 2'b00}) begin
         rxc_q <= I_PWDATA[7:0];
      end else if (wr_ok && I_PADDR == {`SMTX_IDX_TX_STAT_CTRL, 2'b00}) begin
         txc_q <= I_PWDATA[7:0];
      end
   end
   sequence setup_s;
      I_PSEL && !I_PENABLE;
   endsequence
   sequence held3_s(c);
      c [*3];
   endsequence
   pready_next_a:
      assert property (setup_s |=> O_PREADY) else $error("no ready after setup");
   pready_pulse_a:
      assert property (O_PREADY |=> !O_PREADY) else $error("ready held too long");
   err_zero_a:
      assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 0) else $error("bad error reply");
   half_duplex_a:
      assert property (held3_s(cfg_ok && rxc_q[4]) |-> O_DATA_PIN_OE_N)
      else $error("data driven while receiving");
   cfg_float_a:
      assert property (held3_s(!cfg_ok) |-> O_DATA_PIN_OE_N && O_CLK_PIN_OE_N)
      else $error("pins driven outside master mode");
   tx_off_float_a:
      assert property (held3_s(idle) |-> O_DATA_PIN_OE_N && O_CLK_PIN_OE_N)
      else $error("pins driven while disabled");
   data_clk_a:
      assert property (!O_DATA_PIN_OE_N |-> !O_CLK_PIN_OE_N) else $error("data without clock");
   data_fall_a:
      assert property ($fell(O_CLK_PIN_OUT) && !O_DATA_PIN_OE_N |-> $stable(O_DATA_PIN_OUT))
      else $error("data moved at falling edge");
endmodule

bind smtx_top smtx_chk u_chk (.*);

// ---- smtx_peer.sv ----
`timescale 1ns/10ps
module smtx_peer (
   input  wire       i_ck,
   input  wire       i_dt,
   input  wire       i_dev_dt,
   input  wire       i_dev_ck,
   input  wire       i_nine,
   input  wire       i_clr,
   input  wire [7:0] i_rx_byte,
   output reg        o_dt,
   output wire       o_oe,
   output reg  [8:0] o_word,
   output reg        o_vld
);
   reg [8:0] sh;
   reg [3:0] n;
   reg [2:0] rp;
   reg       dev_rise;
   // Answers only while the device listens yet still clocks
   assign o_oe = !i_dev_dt && i_dev_ck;
   initial begin
      n = 4'h0;
      rp = 3'h0;
      o_vld = 1'b0;
      o_dt = 1'b0;
      dev_rise = 1'b0;
   end
   // A bit belongs to the device only if it drove data at the rise before
   always @(posedge i_ck or posedge i_clr) begin
      dev_rise = !i_clr && i_dev_dt && i_dev_ck;
   end
   // Capture LSB first at falling edges, where device data is stable
   always @(negedge i_ck or posedge i_clr) begin
      if (i_clr) begin
         n = 4'h0;
         o_vld = 1'b0;
      end else begin
         if (dev_rise) begin
            sh = {i_dt, sh[8:1]};
            n = n + 4'h1;
         end
         o_vld = dev_rise && (n == (i_nine ? 4'h9 : 4'h8));
         if (o_vld) begin
            o_word = i_nine ? sh : {1'b0, sh[8:1]};
            n = 4'h0;
         end
      end
   end
   // Bit 0 ready before the first rise, next bit after each fall
   always @(posedge o_oe) begin
      rp = 3'h0;
      o_dt = i_rx_byte[0];
   end
   always @(negedge i_ck) begin
      if (o_oe) begin
         rp = rp + 3'h1;
         o_dt = i_rx_byte[rp];
      end
   end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
`include "smtx_regs.vh"
module tb_top;
   localparam logic [5:0] rxc = `SMTX_IDX_RX_STAT_CTRL;
   localparam logic [5:0] txc = `SMTX_IDX_TX_STAT_CTRL;
   localparam logic [5:0] buf_ix = `SMTX_IDX_TX_BUFFER;
   localparam logic [5:0] bank = `SMTX_IDX_BANK_SELECT;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, flt = 1'b0, nine = 1'b0, clr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [7:0]  rxb = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rd;
   logic        er;
   logic [8:0]  exp_q[$];
   int          fails = 0, samples_checked = 0, cyc = 0;
   wire  [31:0] prdata;
   wire  [8:0]  p_word;
   wire         pready, perr, ck_o, ck_oe_n, dt_o, dt_oe_n, p_dt, p_oe, p_vld;
   // Released lines toggle so a floating pin never reads as steady
   wire         ck_w = !ck_oe_n ? ck_o : flt;
   wire         dt_w = !dt_oe_n ? dt_o : (p_oe ? p_dt : flt);
   always #20 clk = ~clk;
   always @(posedge clk) flt <= ~flt;
   smtx_top dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(perr), .I_CLK_PIN_IN(ck_w), .O_CLK_PIN_OUT(ck_o),
      .O_CLK_PIN_OE_N(ck_oe_n), .I_DATA_PIN_IN(dt_w), .O_DATA_PIN_OUT(dt_o),
      .O_DATA_PIN_OE_N(dt_oe_n));
   smtx_peer peer (.i_ck(ck_w), .i_dt(dt_w), .i_dev_dt(!dt_oe_n), .i_dev_ck(!ck_oe_n),
      .i_nine(nine), .i_clr(clr), .i_rx_byte(rxb), .o_dt(p_dt), .o_oe(p_oe),
      .o_word(p_word), .o_vld(p_vld));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Hold the request until ready is seen at an edge
   task apb(input logic w, input logic [5:0] ix, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rchk(input logic [5:0] ix, input logic [7:0] e, input string nm);
      apb(1'b0, ix, 8'h00);
      chk(nm, rd, {24'h0, e});
   endtask
   task send(input logic [7:0] b, input logic n9);
      exp_q.push_back({n9, b});
      apb(1'b1, buf_ix, b);
   endtask
   task drain;
      while (exp_q.size() != 0) @(posedge clk);
      repeat (8) @(posedge clk);
   endtask
   always @(posedge p_vld) begin
      if (exp_q.size() == 0) chk("word unexpected", {23'h0, p_word}, 32'hffff);
      else chk("word", {23'h0, p_word}, {23'h0, exp_q.pop_front()});
   end
   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         end_sim;
      end
   end
   initial begin
      void'($urandom(32'h7ac0));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rchk(txc, 8'h02, "tx ctrl reset");
      apb(1'b1, bank, 8'h01);
      rchk(`SMTX_IDX_IRQ_ENABLES, 8'h00, "irq en reset");
      // Core-level gating lives outside; only the local enable is stored
      apb(1'b1, `SMTX_IDX_IRQ_ENABLES, 8'h02);
      rchk(`SMTX_IDX_IRQ_ENABLES, 8'h02, "irq en rw");
      apb(1'b1, `SMTX_IDX_IRQ_FLAGS, 8'h00);
      rchk(`SMTX_IDX_IRQ_FLAGS, 8'h02, "flag ro");
      apb(1'b1, bank, 8'h00);
      apb(1'b0, 6'h3f, 8'h00);
      chk("unmapped err", {31'h0, er}, 32'h1);
      $display("test registers done");
      // Configure, load, then enable
      apb(1'b1, `SMTX_IDX_BAUD_DIVISOR, 8'h03);
      apb(1'b1, rxc, 8'h80);
      apb(1'b1, txc, 8'h90);
      send(8'($urandom), 1'b0);
      apb(1'b1, txc, 8'hb0);
      drain();
      send(8'($urandom), 1'b0);
      apb(1'b1, bank, 8'h01);
      rchk(`SMTX_IDX_IRQ_FLAGS, 8'h02, "moved at once");
      apb(1'b1, bank, 8'h00);
      send(8'($urandom), 1'b0);
      rchk(txc, 8'hb0, "shifter busy");
      apb(1'b1, bank, 8'h01);
      rchk(`SMTX_IDX_IRQ_FLAGS, 8'h00, "buffer full");
      apb(1'b1, bank, 8'h00);
      drain();
      rchk(txc, 8'hb2, "shifter empty");
      $display("test stream done");
      // Ninth bit both values, then a stale one
      nine <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, txc, 8'hf0 | 8'(k));
         send(8'($urandom), k[0]);
         drain();
      end
      apb(1'b1, txc, 8'hf1);
      send(8'($urandom), 1'b1);
      apb(1'b1, txc, 8'hf0);
      drain();
      nine <= 1'b0;
      apb(1'b1, txc, 8'hb0);
      $display("test nine bit done");
      // Abort mid-word by transmit disable
      apb(1'b1, buf_ix, 8'($urandom));
      repeat (20) @(posedge clk);
      apb(1'b1, txc, 8'h90);
      clr <= 1'b1;
      repeat (3) @(posedge clk);
      clr <= 1'b0;
      chk("dt float", {31'h0, dt_oe_n}, 32'h1);
      chk("ck float", {31'h0, ck_oe_n}, 32'h1);
      rchk(txc, 8'h92, "tx reset");
      apb(1'b1, txc, 8'hb0);
      send(8'($urandom), 1'b0);
      drain();
      $display("test abort done");
      // Single receive interrupts a word, then transmit resumes
      rxb <= 8'($urandom);
      send(8'($urandom), 1'b0);
      repeat (20) @(posedge clk);
      // Land the takeover while the clock is low, after a whole bit went out
      @(posedge ck_o);
      @(posedge clk);
      apb(1'b1, rxc, 8'ha0);
      repeat (6) @(posedge clk);
      chk("rx dt float", {31'h0, dt_oe_n}, 32'h1);
      chk("rx ck driven", {31'h0, ck_oe_n}, 32'h0);
      drain();
      rchk(rxc, 8'h80, "single self clear");
      rchk(`SMTX_IDX_RX_DATA_BUF, rxb, "rx byte");
      apb(1'b1, rxc, 8'h90);
      repeat (40) @(posedge clk);
      chk("cont dt float", {31'h0, dt_oe_n}, 32'h1);
      apb(1'b1, rxc, 8'h00);
      repeat (4) @(posedge clk);
      chk("port off ck", {31'h0, ck_oe_n}, 32'h1);
      $display("test receive done");
      end_sim;
   end
endmodule
